// ### lcd_key_pkg.sv
// Constants and types shared by the key-scan and reset-output block.
// Assumes the internal oscillator period T equals one period of clock.
package lcd_key_pkg;
   // ****************************************************
   // Timing
   // ****************************************************
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned OSC_HZ = 100_000_000;     // Oscillator runs on the block clock
   localparam int unsigned CYC_PER_T = CLK_HZ / OSC_HZ;
   localparam int unsigned SCAN_PERIOD_T = 288;      // One pass over all scan lines, in T
   localparam int unsigned SCAN_AGREE_T = 615;       // Request after two agreeing scans, in T
   localparam int unsigned SCAN_RETRY_T = 1230;      // Request after a rescan, in T
   localparam int unsigned SCAN_PERIOD_CYC = SCAN_PERIOD_T * CYC_PER_T;
   localparam int unsigned SCAN_AGREE_CYC = SCAN_AGREE_T * CYC_PER_T;
   localparam int unsigned SCAN_RETRY_CYC = SCAN_RETRY_T * CYC_PER_T;
   localparam int unsigned SCAN_LINES = 6;
   localparam int unsigned KEY_RETURNS = 5;
   localparam int unsigned KEY_BITS = SCAN_LINES * KEY_RETURNS;
   localparam int unsigned SLOT_CYC = SCAN_PERIOD_CYC / SCAN_LINES;
   localparam int unsigned BASE_HALF_CYC = 256;      // Half period of the display base phase

   // ****************************************************
   // Serial frame
   // ****************************************************
   localparam logic [7:0] DISPLAY_ADDR = 8'h41;
   localparam logic [7:0] CONTROL_ADDR = 8'h42;
   localparam logic [7:0] KEY_READ_ADDR = 8'h43;
   localparam logic [3:0] ADDR_BITS = 4'h8;
   localparam int unsigned DISP_IDX_LSB = 0;         // Transfer number in a display frame
   localparam int unsigned CTL_DUTY_POS = 0;         // 1 selects quarter duty
   localparam int unsigned CTL_SLO_POS = 1;
   localparam int unsigned CTL_SHI_POS = 2;
   localparam int unsigned CTL_SLEEP_POS = 3;
   localparam logic [3:0] THIRD_DUTY_MARKS = 4'h7;
   localparam logic [3:0] QUARTER_DUTY_MARKS = 4'hF;

   // ****************************************************
   // Register port
   // ****************************************************
   localparam logic [1:0] REG_STATUS = 2'h0;         // Sticky events, read only
   localparam logic [1:0] REG_IRQ_EN = 2'h1;         // Event enables
   localparam logic [1:0] REG_IRQ_CLR = 2'h2;        // Write one to clear, write only
   localparam logic [1:0] REG_STATE = 2'h3;          // Live state, read only
   localparam int unsigned EV_REQ = 0;
   localparam int unsigned EV_READ = 1;
   localparam int unsigned EV_RESET_END = 2;
   localparam logic [2:0] IRQ_EN_RESET = 3'h0;

   typedef enum logic [1:0] {
      SCAN_IDLE = 2'h0,
      SCAN_RUN = 2'h1,
      SCAN_HOLD = 2'h3
   } scan_state_t;
endpackage

// ### pin_sync.sv
// Two-stage synchroniser bank for pins entering the clock domain.
// Assumes only the second stage is read by anything outside.
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Pins in, synchronised levels out
   input wire logic [W-1:0] pin,
   output logic [W-1:0] level
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_t;

   sync_t st_reg;
   sync_t st_next;

   // First stage feeds only the second
   always_comb begin
      st_next = st_reg;
      st_next.s1 = pin;
      st_next.s2 = st_reg.s1;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= {INIT, INIT};
      end else begin
         st_reg <= st_next;
      end
   end

   assign level = st_reg.s2;
endmodule

// ### lcd_key_reset.sv
// Reset-time output states, serial link and key-scan request logic of a segment LCD driver.
// Assumes rst_b is the power-on reset; link, reset-source and key-return pins are asynchronous and are synchronised here.
//
// Contract
// - In reset, shared and plain segments and first commons low, line six high.
// - Shared backplane pin is common from power-up until the duty bit chooses.
// - Key lines three to five undriven until both sleep select bits arrive.
// - Data output stays released throughout reset, even during a key read.
// - Two agreeing scans raise the read request 615 periods after scan start.
// - Disagreeing scans with a key held rescan; request comes at 1230 periods.
// - Pull data output low on request; release it while chip enable is high.
// - After the key read, release the request and scan again, keeping sleep.
// - Reset blanks display, stops base clock and scan, clears keys; serial stays alive.
// - Power-on reset ends on the chip-enable fall completing all data; clear pin extends it.
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module lcd_key_reset (
   // Clock and power-on reset
   input wire logic clock,
   input wire logic rst_b,
   // Reset sources
   input wire logic supply_drop_detector,
   input wire logic ext_clear_pin_n,
   // Serial link
   input wire logic chip_enable,
   input wire logic serial_clock_in,
   input wire logic serial_in,
   output logic data_out_oe,
   // Key matrix
   input wire logic [4:0] key_return_in,
   output logic [5:0] key_scan_line_out,
   output logic [5:0] key_scan_line_oe,
   // Display pins
   output logic [7:0] segment_or_port_shared_out,
   output logic [64:0] plain_segment_out,
   output logic [2:0] common_out,
   output logic backplane_or_segment_shared_out,
   output logic backplane_is_common,
   // Register port
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic irq
);
   // ****************************************************
   // State
   // ****************************************************
   typedef struct packed {
      lcd_key_pkg::scan_state_t scan;
      logic [10:0] t;
      logic [5:0] slot;
      logic [2:0] line;
      logic [29:0] buf_a;
      logic [29:0] buf_b;
      logic [29:0] key_data;
      logic req;
      logic por_pending;
      logic in_reset;
      logic duty_known;
      logic duty_quarter;
      logic sleep_known;
      logic sleep_mode;
      logic sel_lo;
      logic sel_hi;
      logic [3:0] disp_mark;
      logic ctl_seen;
      logic ce_d;
      logic sck_d;
      logic [3:0] bit_cnt;
      logic [7:0] addr;
      logic [7:0] payload;
      logic [30:0] rd_shift;
      logic reading;
      logic [8:0] base_cnt;
      logic base_phase;
      logic [2:0] status;
      logic [2:0] irq_en;
      logic [7:0] rdata;
      logic irq;
      logic do_oe;
      logic [5:0] ks_out;
      logic [5:0] ks_oe;
      logic seg_lvl;
      logic com_lvl;
      logic shared_lvl;
      logic shared_common;
   } state_t;

   state_t st_reg;
   state_t st_next;
   logic [9:0] pin_level;
   logic ce_s;
   logic sck_s;
   logic sdi_s;
   logic drop_s;
   logic clr_n_s;
   logic [4:0] ret_s;

   // ****************************************************
   // Pin synchronisers
   // ****************************************************
   pin_sync #(.W(10), .INIT(10'h010)) u_sync (
      .clock(clock),
      .rst_b(rst_b),
      .pin({key_return_in, ext_clear_pin_n, supply_drop_detector, serial_in, serial_clock_in, chip_enable}),
      .level(pin_level)
   );
   assign {ret_s, clr_n_s, drop_s, sdi_s, sck_s, ce_s} = pin_level;

   // ****************************************************
   // Next-state logic
   // ****************************************************
   always_comb begin
      logic sck_rise;
      logic sck_fall;
      logic ce_fall;
      logic [3:0] need;
      logic [2:0] ev;
      logic [5:0] idle_lines;
      logic [29:0] sampled;
      st_next = st_reg;
      sck_rise = sck_s & ~st_reg.sck_d & ce_s;
      sck_fall = ~sck_s & st_reg.sck_d & ce_s;
      ce_fall = ~ce_s & st_reg.ce_d;
      need = st_reg.duty_quarter ? lcd_key_pkg::QUARTER_DUTY_MARKS : lcd_key_pkg::THIRD_DUTY_MARKS;
      ev = 3'h0;
      sampled = 30'h0;
      st_next.ce_d = ce_s;
      st_next.sck_d = sck_s;

      // Serial receiver keeps running in reset
      if (sck_rise) begin
         if (st_reg.bit_cnt < lcd_key_pkg::ADDR_BITS) begin
            st_next.addr = {sdi_s, st_reg.addr[7:1]};
         end else begin
            st_next.payload = {sdi_s, st_reg.payload[7:1]};
         end
         if (st_reg.bit_cnt != 4'hF) begin
            st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
         end
      end
      // Key read: load once the address is in, shift on each falling serial clock
      if (st_reg.bit_cnt == lcd_key_pkg::ADDR_BITS && st_reg.addr == lcd_key_pkg::KEY_READ_ADDR
          && !st_reg.reading) begin
         st_next.reading = 1'b1;
         st_next.rd_shift = {st_reg.sleep_mode, st_reg.key_data};
      end else if (sck_fall && st_reg.reading) begin
         st_next.rd_shift = {1'b1, st_reg.rd_shift[30:1]};
      end
      if (ce_fall) begin
         st_next.bit_cnt = 4'h0;
         st_next.reading = 1'b0;
         if (st_reg.addr == lcd_key_pkg::DISPLAY_ADDR && st_reg.bit_cnt > lcd_key_pkg::ADDR_BITS) begin
            st_next.disp_mark[st_reg.payload[lcd_key_pkg::DISP_IDX_LSB +: 2]] = 1'b1;
         end
         if (st_reg.addr == lcd_key_pkg::CONTROL_ADDR && st_reg.bit_cnt > lcd_key_pkg::ADDR_BITS) begin
            st_next.ctl_seen = 1'b1;
            st_next.duty_known = 1'b1;
            st_next.duty_quarter = st_reg.payload[lcd_key_pkg::CTL_DUTY_POS];
            st_next.sleep_known = 1'b1;
            st_next.sel_lo = st_reg.payload[lcd_key_pkg::CTL_SLO_POS];
            st_next.sel_hi = st_reg.payload[lcd_key_pkg::CTL_SHI_POS];
            st_next.sleep_mode = st_reg.payload[lcd_key_pkg::CTL_SLEEP_POS];
         end
      end
      // Power-on reset clears on the frame end that completes all data
      if (ce_fall && st_next.ctl_seen && ((st_next.disp_mark & need) == need)) begin
         st_next.por_pending = 1'b0;
      end
      if (drop_s) begin
         st_next.por_pending = 1'b1;
         st_next.disp_mark = 4'h0;
         st_next.ctl_seen = 1'b0;
      end
      st_next.in_reset = st_next.por_pending | ~clr_n_s;
      if (st_reg.in_reset && !st_next.in_reset) begin
         ev[lcd_key_pkg::EV_RESET_END] = 1'b1;
      end

      // Idle line levels
      if (!st_reg.sleep_mode) begin
         idle_lines = 6'h3F;
      end else begin
         case ({st_reg.sel_hi, st_reg.sel_lo})
            2'h0: idle_lines = 6'h00;
            2'h1: idle_lines = 6'h30;
            2'h2: idle_lines = 6'h20;
            default: idle_lines = 6'h3F;
         endcase
      end

      // Key scan engine
      case (st_reg.scan)
         lcd_key_pkg::SCAN_IDLE: begin
            if (ret_s != 5'h0) begin
               st_next.scan = lcd_key_pkg::SCAN_RUN;
               st_next.t = 11'h0;
               st_next.slot = 6'h0;
               st_next.line = 3'h0;
               st_next.buf_a = 30'h0;
               st_next.buf_b = 30'h0;
            end
         end
         lcd_key_pkg::SCAN_RUN: begin
            st_next.t = st_reg.t + 11'h1;
            // Sample each line at its slot end
            if (st_reg.t < 11'(2 * lcd_key_pkg::SCAN_PERIOD_CYC)
                || (st_reg.t >= 11'(lcd_key_pkg::SCAN_AGREE_CYC)
                    && st_reg.t < 11'(lcd_key_pkg::SCAN_AGREE_CYC + 2 * lcd_key_pkg::SCAN_PERIOD_CYC))) begin
               if (st_reg.slot == 6'(lcd_key_pkg::SLOT_CYC - 1)) begin
                  st_next.slot = 6'h0;
                  st_next.line = (st_reg.line == 3'(lcd_key_pkg::SCAN_LINES - 1)) ? 3'h0 : st_reg.line + 3'h1;
                  sampled = 30'(ret_s) << (int'(st_reg.line) * lcd_key_pkg::KEY_RETURNS);
                  if ((st_reg.t < 11'(lcd_key_pkg::SCAN_PERIOD_CYC))
                      || (st_reg.t >= 11'(lcd_key_pkg::SCAN_AGREE_CYC)
                          && st_reg.t < 11'(lcd_key_pkg::SCAN_AGREE_CYC + lcd_key_pkg::SCAN_PERIOD_CYC))) begin
                     st_next.buf_a = st_reg.buf_a | sampled;
                  end else begin
                     st_next.buf_b = st_reg.buf_b | sampled;
                  end
               end else begin
                  st_next.slot = st_reg.slot + 6'h1;
               end
            end
            if (st_reg.t == 11'(lcd_key_pkg::SCAN_AGREE_CYC - 1)) begin
               if (st_reg.buf_b == 30'h0) begin
                  st_next.scan = lcd_key_pkg::SCAN_IDLE;            // All keys released
               end else if (st_reg.buf_a == st_reg.buf_b) begin
                  st_next.key_data = st_reg.buf_b;
                  st_next.req = 1'b1;
                  st_next.scan = lcd_key_pkg::SCAN_HOLD;
               end else begin
                  st_next.buf_a = 30'h0;
                  st_next.buf_b = 30'h0;
                  st_next.slot = 6'h0;
                  st_next.line = 3'h0;
               end
            end
            if (st_reg.t == 11'(lcd_key_pkg::SCAN_RETRY_CYC - 1)) begin
               if (st_reg.buf_b == 30'h0) begin
                  st_next.scan = lcd_key_pkg::SCAN_IDLE;
               end else begin
                  st_next.key_data = st_reg.buf_b;
                  st_next.req = 1'b1;
                  st_next.scan = lcd_key_pkg::SCAN_HOLD;
               end
            end
         end
         lcd_key_pkg::SCAN_HOLD: begin
            // Read done: drop request, rescan
            if (ce_fall && st_reg.reading) begin
               st_next.req = 1'b0;
               st_next.scan = lcd_key_pkg::SCAN_RUN;
               st_next.t = 11'h0;
               st_next.slot = 6'h0;
               st_next.line = 3'h0;
               st_next.buf_a = 30'h0;
               st_next.buf_b = 30'h0;
               ev[lcd_key_pkg::EV_READ] = 1'b1;
            end
         end
         default: st_next.scan = lcd_key_pkg::SCAN_IDLE;
      endcase
      if (st_next.req && !st_reg.req) begin
         ev[lcd_key_pkg::EV_REQ] = 1'b1;
      end
      // Reset stops scan, clears keys
      if (st_next.in_reset) begin
         st_next.scan = lcd_key_pkg::SCAN_IDLE;
         st_next.key_data = 30'h0;
         st_next.req = 1'b0;
         st_next.buf_a = 30'h0;
         st_next.buf_b = 30'h0;
      end

      // Base phase, cleared and held at zero in reset
      if (st_next.in_reset) begin
         st_next.base_cnt = 9'h0;
         st_next.base_phase = 1'b0;
      end else if (st_reg.base_cnt == 9'(lcd_key_pkg::BASE_HALF_CYC - 1)) begin
         st_next.base_cnt = 9'h0;
         st_next.base_phase = ~st_reg.base_phase;
      end else begin
         st_next.base_cnt = st_reg.base_cnt + 9'h1;
      end

      // Pin levels
      st_next.shared_common = ~st_next.duty_known | st_next.duty_quarter;
      if (st_next.in_reset) begin
         st_next.seg_lvl = 1'b0;
         st_next.com_lvl = 1'b0;
         st_next.shared_lvl = 1'b0;
         st_next.ks_out = 6'h20;
         st_next.do_oe = 1'b0;
      end else begin
         st_next.seg_lvl = st_next.base_phase;
         st_next.com_lvl = ~st_next.base_phase;
         st_next.shared_lvl = st_next.shared_common ? ~st_next.base_phase : st_next.base_phase;
         if (st_next.scan == lcd_key_pkg::SCAN_RUN) begin
            st_next.ks_out = 6'h01 << st_next.line;
         end else begin
            st_next.ks_out = idle_lines;
         end
         if (st_next.reading) begin
            st_next.do_oe = ~st_next.rd_shift[0];
         end else begin
            st_next.do_oe = st_next.req & ~ce_s;
         end
      end
      st_next.ks_oe = st_next.sleep_known ? 6'h3F : 6'h23;

      // Register port; set beats clear
      if (reg_wr && reg_addr == lcd_key_pkg::REG_IRQ_EN) begin
         st_next.irq_en = reg_wdata[2:0];
      end
      if (reg_wr && reg_addr == lcd_key_pkg::REG_IRQ_CLR) begin
         st_next.status = (st_reg.status & ~reg_wdata[2:0]) | ev;
      end else begin
         st_next.status = st_reg.status | ev;
      end
      st_next.irq = |(st_next.status & st_next.irq_en);
      st_next.rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            lcd_key_pkg::REG_STATUS: st_next.rdata = {5'h00, st_reg.status};
            lcd_key_pkg::REG_IRQ_EN: st_next.rdata = {5'h00, st_reg.irq_en};
            lcd_key_pkg::REG_STATE: st_next.rdata = {2'h0, st_reg.in_reset, st_reg.req, st_reg.sleep_mode,
                                                     st_reg.duty_quarter, st_reg.scan};
            default: st_next.rdata = 8'h00;
         endcase
      end
   end

   // ****************************************************
   // State register
   // ****************************************************
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '0;
         st_reg.por_pending <= 1'b1;
         st_reg.in_reset <= 1'b1;
         st_reg.scan <= lcd_key_pkg::SCAN_IDLE;
         st_reg.irq_en <= lcd_key_pkg::IRQ_EN_RESET;
         st_reg.rd_shift <= 31'h7FFFFFFF;
         st_reg.ks_out <= 6'h20;
         st_reg.ks_oe <= 6'h23;
         st_reg.shared_common <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from the state register
   assign data_out_oe = st_reg.do_oe;
   assign key_scan_line_out = st_reg.ks_out;
   assign key_scan_line_oe = st_reg.ks_oe;
   assign segment_or_port_shared_out = {8{st_reg.seg_lvl}};
   assign plain_segment_out = {65{st_reg.seg_lvl}};
   assign common_out = {3{st_reg.com_lvl}};
   assign backplane_or_segment_shared_out = st_reg.shared_lvl;
   assign backplane_is_common = st_reg.shared_common;
   assign reg_rdata = st_reg.rdata;
   assign irq = st_reg.irq;
endmodule

// ### lcd_key_reset_monitor.sv
// Checker for the reset-time pins, the data output and the register port.
// Assumes it is bound to lcd_key_reset and sees only that module's ports.
`timescale 1ns/1ps
module lcd_key_reset_monitor (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Link and key pins
   input wire logic chip_enable,
   input wire logic data_out_oe,
   input wire logic [5:0] key_scan_line_out,
   input wire logic [5:0] key_scan_line_oe,
   // Display pins
   input wire logic [7:0] segment_or_port_shared_out,
   input wire logic [64:0] plain_segment_out,
   input wire logic [2:0] common_out,
   input wire logic backplane_or_segment_shared_out,
   input wire logic backplane_is_common,
   // Register port
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   logic no_frame;
   // No frame yet means still in reset
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) no_frame <= 1'b1;
      else if (chip_enable) no_frame <= 1'b0;
   end
   // ****************************************************
   // Properties
   // ****************************************************
   property p_reset_pins;
      no_frame |-> segment_or_port_shared_out == 8'h00 && plain_segment_out == 65'h0 && common_out == 3'h0
         && !backplane_or_segment_shared_out && key_scan_line_out[5] && key_scan_line_out[1:0] == 2'h0;
   endproperty
   a_reset_pins: assert property (p_reset_pins) else $error("pin level wrong in reset");
   property p_bp_common;
      no_frame |-> backplane_is_common;
   endproperty
   a_bp_common: assert property (p_bp_common) else $error("shared pin not common at power-up");
   property p_lines_free;
      no_frame |-> key_scan_line_oe[4:2] == 3'h0;
   endproperty
   a_lines_free: assert property (p_lines_free) else $error("key lines three to five driven early");
   property p_do_reset;
      no_frame |-> !data_out_oe;
   endproperty
   a_do_reset: assert property (p_do_reset) else $error("data pin pulled in reset");
   // Request off the pin early in a frame
   property p_ce_release;
      $rose(chip_enable) |-> ##6 !data_out_oe;
   endproperty
   a_ce_release: assert property (p_ce_release) else $error("data pin held with chip enable high");
   property p_state_in_reset;
      reg_rd && reg_addr == lcd_key_pkg::REG_STATE && no_frame |=> reg_rdata[5];
   endproperty
   a_state_in_reset: assert property (p_state_in_reset) else $error("state shows reset over");
   property p_rdata_idle;
      !reg_rd |=> reg_rdata == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data without a read");
   property p_irq_mask;
      reg_wr && reg_addr == lcd_key_pkg::REG_IRQ_EN && reg_wdata[2:0] == 3'h0 |-> ##2 !irq;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("interrupt high with all enables off");
   c_request: cover property ($rose(data_out_oe));
   c_irq: cover property ($rose(irq));
   c_state_read: cover property (reg_rd && reg_addr == lcd_key_pkg::REG_STATE);
endmodule
bind lcd_key_reset lcd_key_reset_monitor u_mon (.clock, .rst_b, .chip_enable, .data_out_oe, .key_scan_line_out,
   .key_scan_line_oe, .segment_or_port_shared_out, .plain_segment_out, .common_out, .backplane_or_segment_shared_out,
   .backplane_is_common, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);

// ### link_controller.sv
// System controller model on the three-wire link: sends frames and reads key data.
// Assumes the data pin is pulled up, so it reads high while the device lets go.
`timescale 1ns/1ps
module link_controller (
   // Clock
   input wire logic clock,
   // Link pins
   output logic chip_enable,
   output logic serial_clock_in,
   output logic serial_in,
   input wire logic data_pin
);
   // Serial clock stands low outside frames
   initial begin
      chip_enable = 1'b0;
      serial_clock_in = 1'b0;
      serial_in = 1'b0;
   end
   // ****************************************************
   // Transfers
   // ****************************************************
   // One bit: sample pin, fall with data, rise
   task automatic bit_cyc(input logic b, output logic s);
      s = data_pin;
      serial_clock_in <= 1'b0;
      serial_in <= b;
      repeat (8) @(posedge clock);
      serial_clock_in <= 1'b1;
      repeat (6) @(posedge clock);
   endtask
   // Address byte, then n sampled bits
   task automatic frame(input logic [7:0] addr, input logic [7:0] pay, input int n, output logic [30:0] rd,
      output logic valid);
      logic s;
      valid = !data_pin;
      chip_enable <= 1'b1;
      for (int i = 0; i < 8; i++) bit_cyc(addr[i], s);
      for (int i = 0; i < n; i++) begin
         bit_cyc(pay[i % 8], s);
         rd[i] = s;
      end
      chip_enable <= 1'b0;
      serial_clock_in <= 1'b0;
      serial_in <= ~serial_in;
      repeat (6) @(posedge clock);
   endtask
endmodule

// ### testbench.sv
// Self-checking bench for the reset-output and key-read block.
// Assumes a pulled-up data pin and a key matrix with one diode per key.
`timescale 1ns/1ps
module testbench;
   typedef struct packed {logic wr; logic [1:0] addr; logic [7:0] data; logic [7:0] exp; logic irq;} row_t;
   logic clock, rst_b, ext_clear_pin_n, chip_enable, serial_clock_in, serial_in, data_out_oe, irq, pin, valid;
   logic reg_wr, reg_rd, bp_out, bp_common;
   logic [1:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, seg, d;
   logic [4:0] key_return_in;
   logic [5:0] ks_out, ks_oe;
   logic [64:0] plain;
   logic [2:0] com;
   logic [29:0] keys;
   logic [30:0] rd;
   int mismatches, cmp_count, n;
   // Rows: write, address, data, read data, irq
   row_t rows [11] = '{{1'b0, 2'h1, 8'h00, 8'h00, 1'b0}, {1'b1, 2'h1, 8'h07, 8'h00, 1'b0},
      {1'b0, 2'h1, 8'h00, 8'h07, 1'b1}, {1'b0, 2'h0, 8'h00, 8'h04, 1'b1}, {1'b0, 2'h2, 8'h00, 8'h00, 1'b1},
      {1'b1, 2'h0, 8'hFF, 8'h00, 1'b0}, {1'b0, 2'h0, 8'h00, 8'h04, 1'b1}, {1'b1, 2'h2, 8'h04, 8'h00, 1'b0},
      {1'b0, 2'h0, 8'h00, 8'h00, 1'b0}, {1'b0, 2'h3, 8'h00, 8'h04, 1'b0}, {1'b1, 2'h1, 8'h00, 8'h00, 1'b0}};
   assign pin = data_out_oe ? 1'b0 : 1'b1;
   // Key matrix with one diode per key
   always_comb begin
      key_return_in = 5'h00;
      for (int l = 0; l < 6; l++)
         for (int r = 0; r < 5; r++)
            if (ks_oe[l] && ks_out[l] && keys[l * 5 + r]) key_return_in[r] = 1'b1;
   end
   lcd_key_reset DUT (.clock(clock), .rst_b(rst_b), .supply_drop_detector(1'b0), .ext_clear_pin_n(ext_clear_pin_n),
      .chip_enable(chip_enable), .serial_clock_in(serial_clock_in), .serial_in(serial_in), .data_out_oe(data_out_oe),
      .key_return_in(key_return_in), .key_scan_line_out(ks_out), .key_scan_line_oe(ks_oe),
      .segment_or_port_shared_out(seg), .plain_segment_out(plain), .common_out(com),
      .backplane_or_segment_shared_out(bp_out), .backplane_is_common(bp_common), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
   link_controller u_ctl (.clock(clock), .chip_enable(chip_enable), .serial_clock_in(serial_clock_in),
      .serial_in(serial_in), .data_pin(pin));
   // ****************************************************
   // Tasks
   // ****************************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic reg_write(input logic [1:0] a, input logic [7:0] v);
      @(posedge clock);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [1:0] a, output logic [7:0] v);
      @(posedge clock);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   // Bounded wait for the request
   task automatic wait_req(input int lo, input int hi);
      n = 0;
      while (data_out_oe !== 1'b1 && n < 2000) begin
         @(posedge clock);
         #1 n++;
      end
      check(n >= lo && n <= hi, 1);
      if (n >= 2000) close_out();
   endtask
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Hang guard
   initial begin
      repeat (100000) @(posedge clock);
      mismatches++;
      close_out();
   end
   // ****************************************************
   // Main sequence
   // ****************************************************
   initial begin
      {rst_b, ext_clear_pin_n, reg_wr, reg_rd, reg_addr, reg_wdata, keys} = {2'b01, 12'h000, 30'h0};
      repeat (16) @(posedge clock);
      rst_b <= 1'b1;
      keys <= 30'h1 << 25;
      repeat (700) @(posedge clock);
      check({seg == 8'h00, plain == 65'h0, com == 3'h0, bp_out, ks_out[5], ks_out[1:0]}, 7'h74);
      check(data_out_oe, 0);
      reg_read(lcd_key_pkg::REG_STATE, d);
      check(d, 8'h20);
      u_ctl.frame(lcd_key_pkg::KEY_READ_ADDR, 8'h00, 31, rd, valid);
      check({valid, rd}, 32'h7FFFFFFF);
      keys <= 30'h0;
      ext_clear_pin_n <= 1'b0;
      // Duty bit picks the pin function
      u_ctl.frame(lcd_key_pkg::CONTROL_ADDR, 8'h06, 8, rd, valid);
      check(bp_common, 0);
      u_ctl.frame(lcd_key_pkg::CONTROL_ADDR, 8'h07, 8, rd, valid);
      check(bp_common, 1);
      for (int i = 0; i < 4; i++) u_ctl.frame(lcd_key_pkg::DISPLAY_ADDR, 8'(i), 8, rd, valid);
      reg_read(lcd_key_pkg::REG_STATE, d);
      check(d, 8'h24);
      ext_clear_pin_n <= 1'b1;
      repeat (10) @(posedge clock);
      foreach (rows[i]) begin
         if (rows[i].wr) reg_write(rows[i].addr, rows[i].data);
         else begin
            reg_read(rows[i].addr, d);
            check({d, irq}, {rows[i].exp, rows[i].irq});
         end
      end
      // Two agreeing scans, key released before the read
      keys <= 30'h1 << 7;
      wait_req(615, 625);
      keys <= 30'h0;
      u_ctl.frame(lcd_key_pkg::KEY_READ_ADDR, 8'h00, 31, rd, valid);
      check({valid, rd}, 32'h80000080);
      repeat (1300) @(posedge clock);
      check(data_out_oe, 0);
      reg_read(lcd_key_pkg::REG_STATUS, d);
      check(d, 8'h03);
      // Key moves during the first pass: rescan
      keys <= 30'h1;
      repeat (200) @(posedge clock);
      keys <= 30'h1 << 5;
      wait_req(1030, 1040);
      keys <= 30'h0;
      u_ctl.frame(lcd_key_pkg::KEY_READ_ADDR, 8'h00, 31, rd, valid);
      check(rd, 32'h20);
      close_out();
   end
endmodule
